// *** hw/dms_pkg.sv ***
// Shared constants of the micro-sequencer: sizes, field layout, opcodes, registers
package dms_pkg;

	////////////////////////////////////////////////////////////////////////////
	localparam int         WORD_W      = 32;
	localparam int         PC_W        = 9;
	localparam int         STORE_DEPTH = 384;
	localparam int         BUS_W       = 24;
	localparam int         CNT_W       = 5;
	localparam int         RET_W       = 8;
	localparam int         COND_W      = 8;
	localparam int         STEP_W      = 10;
	localparam logic [8:0] PC_LAST     = 9'h17f;
	localparam logic [8:0] PC_ZERO     = 9'h000;
	localparam logic [8:0] PC_ONE      = 9'h001;

	////////////////////////////////////////////////////////////////////////////
	// Instruction word fields
	localparam int OP_HI   = 31;
	localparam int OP_LO   = 28;
	localparam int DST_HI  = 27;
	localparam int DST_LO  = 24;
	localparam int SRC_HI  = 23;
	localparam int SRC_LO  = 20;
	localparam int LIT_HI  = 23;
	localparam int CNT_HI  = 21;
	localparam int CNT_LO  = 17;
	localparam int CC_HI   = 19;
	localparam int CC_LO   = 17;
	localparam int RET_HI  = 16;
	localparam int RET_LO  = 9;
	localparam int TGT_HI  = 8;

	localparam logic [3:0] OP_EXEC = 4'h0;
	localparam logic [3:0] OP_JMP  = 4'h1;
	localparam logic [3:0] OP_JC   = 4'h2;
	localparam logic [3:0] OP_JX   = 4'h3;
	localparam logic [3:0] OP_CALL = 4'h4;
	localparam logic [3:0] OP_LOOP = 4'h5;
	localparam logic [3:0] OP_LOAD = 4'h6;
	localparam logic [3:0] OP_END  = 4'h7;

	localparam logic [2:0] CC_SIGN_SET = 3'h0;
	localparam logic [2:0] CC_SIGN_CLR = 3'h1;
	localparam logic [2:0] CC_OVF_SET  = 3'h2;
	localparam logic [2:0] CC_OVF_CLR  = 3'h3;
	localparam logic [2:0] CC_ZERO_SET = 3'h4;
	localparam logic [2:0] CC_ZERO_CLR = 3'h5;

	localparam logic [3:0] SRC_NONE = 4'h0;
	localparam logic [3:0] SRC_WIDE = 4'h1;
	localparam logic [3:0] SRC_HALF = 4'h2;
	localparam logic [3:0] SRC_BYTE = 4'h3;

	localparam logic [3:0] DST_NONE       = 4'h0;
	localparam logic [3:0] DST_WRITE_LOW  = 4'h1;

	////////////////////////////////////////////////////////////////////////////
	// Register byte offsets and reset values
	localparam logic [7:0] REG_CTRL      = 8'h00;
	localparam logic [7:0] REG_LOAD_ADDR = 8'h04;
	localparam logic [7:0] REG_LOAD_DATA = 8'h08;
	localparam logic [7:0] REG_STATUS    = 8'h0c;
	localparam logic [7:0] REG_EXT_COND  = 8'h10;
	localparam logic [7:0] REG_FLAGS     = 8'h14;
	localparam logic [7:0] REG_BUS       = 8'h18;
	localparam int         CTRL_RUN_BIT  = 0;
	localparam logic       RUN_RESET     = 1'b0;

	typedef enum logic [1:0] {SEQ_IDLE, SEQ_RUN, SEQ_WAIT} dms_seq_state_t;

endpackage : dms_pkg

// *** hw/dms_program_store.sv ***
// Program store: 384 words, one write port, one registered read port
`timescale 1ns/10ps
module dms_program_store
	import dms_pkg::*;
(
	input  wire logic              clock,
	input  wire logic              ce,
	input  wire logic              writeEn,
	input  wire logic [PC_W-1:0]   writeAddr,
	input  wire logic [WORD_W-1:0] writeData,
	input  wire logic [PC_W-1:0]   readAddr,
	output logic      [WORD_W-1:0] readData
);

	logic [WORD_W-1:0] mem [0:STORE_DEPTH-1];

	// No reset on the array so it maps onto a plain RAM
	always_ff @(posedge clock) begin
		if (ce && writeEn && writeAddr <= PC_LAST) begin
			mem[writeAddr] <= writeData;
		end
	end

	always_ff @(posedge clock) begin
		if (ce) begin
			readData <= (readAddr <= PC_LAST) ? mem[readAddr] : '0;
		end
	end

endmodule : dms_program_store

// *** hw/dms_data_bus.sv ***
// Source selection and alignment onto the internal data bus
`timescale 1ns/10ps
module dms_data_bus
	import dms_pkg::*;
(
	input  wire logic             enable,
	input  wire logic             isLoad,
	input  wire logic [BUS_W-1:0] literal,
	input  wire logic [3:0]       srcSel,
	input  wire logic [23:0]      srcWide,
	input  wire logic [15:0]      srcHalf,
	input  wire logic [7:0]       srcByte,
	output logic      [BUS_W-1:0] busValue
);

	always_comb begin
		busValue = '0;
		if (enable && isLoad) begin
			busValue = literal;
		end else if (enable) begin
			case (srcSel)
				SRC_WIDE: busValue = srcWide;
				SRC_HALF: busValue = {srcHalf, 8'h00};
				SRC_BYTE: busValue = {srcByte, 16'h0000};
				default:  busValue = '0;
			endcase
		end
	end

endmodule : dms_data_bus

// *** hw/dms_micro_sequencer.sv ***
// Micro-program sequencer top: program store load, fetch/execute, data bus, AHB-Lite registers
//
// Design decisions made here: the address map and the AHB-Lite register port.
`timescale 1ns/10ps
module dms_micro_sequencer
	import dms_pkg::*;
(
	input  wire logic              clock,
	input  wire logic              rst_n,
	input  wire logic              ce,
	input  wire logic              hsel,
	input  wire logic [31:0]       haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	output logic                   hreadyout,
	output logic                   hresp,
	output logic      [31:0]       hrdata,
	input  wire logic              sampleClockPin,
	input  wire logic [COND_W-1:0] extCondPin,
	input  wire logic              aluSign,
	input  wire logic              aluOverflow,
	input  wire logic              aluZero,
	input  wire logic              aluFlagUpdate,
	input  wire logic [23:0]       srcWide,
	input  wire logic [15:0]       srcHalf,
	input  wire logic [7:0]        srcByte,
	output logic      [BUS_W-1:0]  dataBus,
	output logic      [3:0]        dataDest,
	output logic                   dataWrite,
	output logic      [15:0]       destHigh16,
	output logic      [7:0]        destLowByte,
	output logic      [WORD_W-1:0] microWord,
	output logic                   microValid
);

	////////////////////////////////////////////////////////////////////////////
	logic                 run;
	logic [PC_W-1:0]      loadAddr;
	dms_seq_state_t       seqState;
	logic [PC_W-1:0]      pc;
	logic [PC_W-1:0]      execPc;
	logic                 execValid;
	logic [WORD_W-1:0]    execWord;
	logic [PC_W-1:0]      stackAddr;
	logic                 stackValid;
	logic [RET_W-1:0]     returnReg;
	logic [PC_W-1:0]      loopStart;
	logic                 loopActive;
	logic [CNT_W-1:0]     loopRemain;
	logic                 sampleSync1;
	logic                 sampleSync2;
	logic                 samplePrev;
	logic [COND_W-1:0]    extSync1;
	logic [COND_W-1:0]    extSync2;
	logic [COND_W-1:0]    extCond;
	logic                 signFlag;
	logic                 overflowFlag;
	logic                 zeroFlag;
	logic [STEP_W-1:0]    stepCount;
	logic                 dataPhase;
	logic                 phaseWrite;
	logic [7:0]           phaseAddr;
	logic [PC_W-1:0]      lastTarget;

	logic                 sampleEdge;
	logic                 running;
	logic                 startGo;
	logic [3:0]           op;
	logic                 condMet;
	logic                 extHit;
	logic                 takeBranch;
	logic                 execEnd;
	logic                 execLoop;
	logic [RET_W-1:0]     retEff;
	logic [CNT_W-1:0]     remainEff;
	logic [PC_W-1:0]      startEff;
	logic                 loopEff;
	logic                 seqFree;
	logic                 loopWrap;
	logic                 loopExit;
	logic                 subReturn;
	logic [PC_W-1:0]      next_pc;
	logic                 next_execValid;
	logic                 storeWrite;
	logic                 busEnable;
	logic [BUS_W-1:0]     busValue;
	logic [31:0]          readMux;

	////////////////////////////////////////////////////////////////////////////
	// Sample clock and condition pins: two flops before any use
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sampleSync1 <= 1'b0;
			sampleSync2 <= 1'b0;
			samplePrev  <= 1'b0;
			extSync1    <= '0;
			extSync2    <= '0;
			extCond     <= '0;
		end else if (ce) begin
			sampleSync1 <= sampleClockPin;
			sampleSync2 <= sampleSync1;
			samplePrev  <= sampleSync2;
			extSync1    <= extCondPin;
			extSync2    <= extSync1;
			// Captured whether running or held
			if (sampleEdge) begin
				extCond <= extSync2;
			end
		end
	end

	assign sampleEdge = sampleSync2 && !samplePrev;

	// Flags only move on an ALU operation that updates them
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			signFlag     <= 1'b0;
			overflowFlag <= 1'b0;
			zeroFlag     <= 1'b0;
		end else if (ce && aluFlagUpdate) begin
			signFlag     <= aluSign;
			overflowFlag <= aluOverflow;
			zeroFlag     <= aluZero;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Execute-stage decode
	always_comb begin
		op      = execWord[OP_HI:OP_LO];
		running = run && seqState == SEQ_RUN;
		case (execWord[CC_HI:CC_LO])
			CC_SIGN_SET: condMet = signFlag;
			CC_SIGN_CLR: condMet = !signFlag;
			CC_OVF_SET:  condMet = overflowFlag;
			CC_OVF_CLR:  condMet = !overflowFlag;
			CC_ZERO_SET: condMet = zeroFlag;
			CC_ZERO_CLR: condMet = !zeroFlag;
			default:     condMet = 1'b0;
		endcase
		extHit     = |(execWord[RET_HI:RET_LO] & extCond);
		takeBranch = running && execValid && (op == OP_JMP || op == OP_CALL
			|| (op == OP_JC && condMet) || (op == OP_JX && extHit));
		execEnd    = running && execValid && op == OP_END;
		execLoop   = running && execValid && op == OP_LOOP;
	end

	// A loop just decoded already governs the fetch in flight
	always_comb begin
		if (execLoop) begin
			retEff    = execWord[RET_HI:RET_LO];
			remainEff = (execWord[CNT_HI:CNT_LO] == '0) ? '0
				: execWord[CNT_HI:CNT_LO] - 5'h01;
			startEff  = execPc + PC_ONE;
			loopEff   = 1'b1;
		end else begin
			retEff    = returnReg;
			remainEff = loopRemain;
			startEff  = loopStart;
			loopEff   = loopActive;
		end
		seqFree   = running && !execEnd && !takeBranch;
		loopWrap  = seqFree && loopEff && pc == {1'b0, retEff} && remainEff != '0;
		loopExit  = seqFree && loopEff && pc == {1'b0, retEff} && remainEff == '0;
		subReturn = seqFree && stackValid && pc == {1'b0, returnReg};
		startGo   = run && ((seqState == SEQ_IDLE)
			|| (seqState == SEQ_WAIT && sampleEdge));
	end

	// Fetch address; a taken jump or call, or an end, squashes the word already read
	always_comb begin
		next_pc        = (pc == PC_LAST) ? PC_ZERO : pc + PC_ONE;
		next_execValid = 1'b1;
		if (!run || (seqState != SEQ_RUN && !startGo)) begin
			next_pc        = PC_ZERO;
			next_execValid = 1'b0;
		end else if (seqState != SEQ_RUN) begin
			next_pc        = PC_ONE;
		end else if (execEnd) begin
			next_pc        = PC_ZERO;
			next_execValid = 1'b0;
		end else if (takeBranch) begin
			next_pc        = execWord[TGT_HI:0];
			next_execValid = 1'b0;
		end else if (subReturn) begin
			next_pc        = stackAddr;
		end else if (loopWrap) begin
			next_pc        = startEff;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			seqState <= SEQ_IDLE;
		end else if (ce) begin
			case (seqState)
				SEQ_IDLE: seqState <= run ? SEQ_RUN : SEQ_IDLE;
				SEQ_RUN:  seqState <= !run ? SEQ_IDLE : (execEnd ? SEQ_WAIT : SEQ_RUN);
				SEQ_WAIT: seqState <= !run ? SEQ_IDLE : (sampleEdge ? SEQ_RUN : SEQ_WAIT);
				default:  seqState <= SEQ_IDLE;
			endcase
		end
	end

	// Fetch then execute: two cycles, three on a taken jump or call
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pc         <= PC_ZERO;
			execPc     <= PC_ZERO;
			execValid  <= 1'b0;
			lastTarget <= PC_ZERO;
		end else if (ce) begin
			pc        <= next_pc;
			execPc    <= pc;
			execValid <= next_execValid;
			if (takeBranch) begin
				lastTarget <= execWord[TGT_HI:0];
			end
		end
	end

	// Call and loop share the return register; programs never nest them
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			stackAddr  <= PC_ZERO;
			stackValid <= 1'b0;
			returnReg  <= '0;
			loopStart  <= PC_ZERO;
			loopActive <= 1'b0;
			loopRemain <= '0;
		end else if (ce) begin
			if (!running) begin
				stackValid <= 1'b0;
				loopActive <= 1'b0;
				loopRemain <= '0;
			end else begin
				if (execValid && op == OP_CALL) begin
					stackAddr  <= execPc + PC_ONE;
					stackValid <= 1'b1;
					returnReg  <= execWord[RET_HI:RET_LO];
				end else if (subReturn) begin
					stackValid <= 1'b0;
				end
				if (execLoop) begin
					returnReg <= retEff;
					loopStart <= startEff;
				end
				loopActive <= loopEff && !loopExit;
				loopRemain <= loopWrap ? remainEff - 5'h01 : remainEff;
			end
		end
	end

	// Steps executed since the last sample-clock rise
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			stepCount <= '0;
		end else if (ce) begin
			if (sampleEdge) begin
				stepCount <= '0;
			end else if (running && execValid && stepCount != '1) begin
				stepCount <= stepCount + 10'h001;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Program store, written only while the sequencer is held
	assign storeWrite = dataPhase && phaseWrite && phaseAddr == REG_LOAD_DATA && !run;

	dms_program_store u_store (
		.clock     (clock),
		.ce        (ce),
		.writeEn   (storeWrite),
		.writeAddr (loadAddr),
		.writeData (hwdata),
		.readAddr  (pc),
		.readData  (execWord)
	);

	assign busEnable = running && execValid && (op == OP_LOAD || op == OP_EXEC);

	dms_data_bus u_bus (
		.enable   (busEnable),
		.isLoad   (op == OP_LOAD),
		.literal  (execWord[LIT_HI:0]),
		.srcSel   (execWord[SRC_HI:SRC_LO]),
		.srcWide  (srcWide),
		.srcHalf  (srcHalf),
		.srcByte  (srcByte),
		.busValue (busValue)
	);

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			dataBus     <= '0;
			dataDest    <= DST_NONE;
			dataWrite   <= 1'b0;
			destHigh16  <= '0;
			destLowByte <= '0;
			microWord   <= '0;
			microValid  <= 1'b0;
		end else if (ce) begin
			dataBus     <= busValue;
			dataDest    <= busEnable ? execWord[DST_HI:DST_LO] : DST_NONE;
			dataWrite   <= busEnable && execWord[DST_HI:DST_LO] != DST_NONE;
			destHigh16  <= busValue[23:8];
			destLowByte <= (execWord[DST_HI:DST_LO] == DST_WRITE_LOW)
				? busValue[7:0] : busValue[23:16];
			microWord   <= (running && execValid) ? execWord : '0;
			microValid  <= running && execValid;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// AHB-Lite slave, zero wait states, always OKAY
	always_comb begin
		case (haddr[7:0])
			REG_CTRL:      readMux = {31'h0, run};
			REG_LOAD_ADDR: readMux = {23'h0, loadAddr};
			REG_STATUS:    readMux = {5'h00, stepCount, loopRemain, loopActive,
				stackValid, seqState == SEQ_WAIT, pc};
			REG_EXT_COND:  readMux = {24'h0, extCond};
			REG_FLAGS:     readMux = {29'h0, signFlag, overflowFlag, zeroFlag};
			REG_BUS:       readMux = {8'h00, dataBus};
			default:       readMux = '0;
		endcase
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			dataPhase  <= 1'b0;
			phaseWrite <= 1'b0;
			phaseAddr  <= '0;
			hrdata     <= '0;
			hreadyout  <= 1'b1;
			hresp      <= 1'b0;
		end else if (ce) begin
			dataPhase  <= hsel && htrans[1] && hready;
			phaseWrite <= hwrite;
			phaseAddr  <= haddr[7:0];
			hrdata     <= (hsel && htrans[1] && hready && !hwrite) ? readMux : '0;
			hreadyout  <= 1'b1;
			hresp      <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			run      <= RUN_RESET;
			loadAddr <= PC_ZERO;
		end else if (ce && dataPhase && phaseWrite) begin
			case (phaseAddr)
				REG_CTRL:      run <= hwdata[CTRL_RUN_BIT];
				REG_LOAD_ADDR: loadAddr <= hwdata[PC_W-1:0];
				REG_LOAD_DATA: if (!run) loadAddr <= (loadAddr == PC_LAST) ? PC_ZERO
					: loadAddr + PC_ONE;
				default:       loadAddr <= loadAddr;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n || !ce);

	sequence s_one_nop;
		!execValid ##1 (execValid && execPc == lastTarget);
	endsequence

	a_jump_one_nop: assert property ((takeBranch && op == OP_JMP) |=> s_one_nop)
		else $error("jump did not insert exactly one idle cycle");
	a_cond_taken: assert property ((takeBranch && op == OP_JC) |=> s_one_nop)
		else $error("taken conditional jump timing wrong");
	a_cond_fallthrough: assert property ((running && execValid && op == OP_JC && !condMet
		&& !loopEff && !stackValid) |=> (execValid && execPc == $past(execPc) + PC_ONE))
		else $error("untaken conditional jump lost a cycle");
	a_extjump_taken: assert property ((running && execValid && op == OP_JX && extHit)
		|=> s_one_nop)
		else $error("external condition jump not taken correctly");
	a_call_push: assert property ((takeBranch && op == OP_CALL)
		|=> (stackValid && stackAddr == $past(execPc) + PC_ONE) ##0 s_one_nop)
		else $error("call did not stack next address");
	a_return_direct: assert property (subReturn |=> ##1 (execValid
		&& execPc == $past(stackAddr, 2)))
		else $error("return inserted an idle cycle");
	a_loop_wrap: assert property (loopWrap |=> ##1 (execValid
		&& execPc == $past(startEff, 2)))
		else $error("loop wrap did not return to body start");
	a_end_waits: assert property ((seqState == SEQ_WAIT && run && !sampleEdge)
		|=> (seqState == SEQ_WAIT && !execValid))
		else $error("end state left without sample edge");
	a_restart_zero: assert property ((seqState == SEQ_WAIT && run && sampleEdge)
		|=> (execValid && execPc == PC_ZERO))
		else $error("period did not restart at address zero");
	a_load_literal: assert property ((running && execValid && op == OP_LOAD)
		|=> (dataBus == $past(execWord[LIT_HI:0])))
		else $error("load literal not on data bus");
	a_bus_held_zero: assert property (!run |=> (dataBus == '0 && !dataWrite))
		else $error("data bus not zero while held");
	a_cond_capture: assert property (sampleEdge |=> (extCond == $past(extSync2)))
		else $error("condition register missed sample edge");

endmodule : dms_micro_sequencer

// *** bench/dms_host_model.sv ***
// Host-side AHB-Lite master that loads the program store and reaches the registers
`timescale 1ns/10ps
module dms_host_model (
	input  wire logic        clock,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata,
	output logic      [31:0] haddr,
	output logic      [1:0]  htrans,
	output logic             hwrite,
	output logic      [31:0] hwdata,
	output logic             hung
);
	initial begin
		haddr  = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		hung   = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////
	// Bounded wait; a stuck slave raises hung instead of hanging the run
	task automatic wait_ready();
		int n;
		n = 0;
		@(posedge clock);
		while (hready !== 1'b1 && n < 16) begin
			n++;
			@(posedge clock);
		end
		if (n == 16) hung <= 1'b1;
	endtask : wait_ready

	// Called right after a rising edge; single word transfer
	task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wdata,
		output logic [31:0] rdata);
		htrans <= 2'h2;
		haddr  <= addr;
		hwrite <= wr;
		wait_ready();
		htrans <= 2'h0;
		hwdata <= wdata;
		wait_ready();
		rdata = hrdata;
		// Released data lines show garbage, not the old word
		hwdata <= ~wdata;
	endtask : xfer
endmodule : dms_host_model

// *** bench/tb_dms_micro_sequencer.sv ***
// Self-checking bench: program load, sequencing timing, data bus alignment, registers
`timescale 1ns/10ps
module tb_dms_micro_sequencer;
	import dms_pkg::*;
	logic        clock, rst_n, hreadyout, hresp, hwrite, hung, microValid, sampleClockPin;
	logic        aluZero, aluFlagUpdate, aluSign, aluOverflow, dataWrite;
	logic [3:0]  dataDest;
	logic [15:0] destHigh16;
	logic [7:0]  destLowByte;
	logic [31:0] hrdata, haddr, hwdata, microWord, rd;
	logic [1:0]  htrans;
	logic [7:0]  extCondPin, srcByte, cond;
	logic [15:0] srcHalf;
	logic [23:0] srcWide, dataBus, lit;
	logic [31:0] prog[14];
	logic [31:0] expT[17];
	logic [31:0] trW[17];
	logic [23:0] trB[17];
	logic [31:0] trX[17];
	int          err_count, n_compared, seed, nTr, n, p;
	logic        rec;

	dms_host_model i_host (.clock(clock), .hready(hreadyout), .hrdata(hrdata), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hung(hung));

	dms_micro_sequencer i_dut (.clock(clock), .rst_n(rst_n), .ce(1'b1), .hsel(1'b1),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.sampleClockPin(sampleClockPin), .extCondPin(extCondPin), .aluSign(aluSign),
		.aluOverflow(aluOverflow), .aluZero(aluZero), .aluFlagUpdate(aluFlagUpdate),
		.srcWide(srcWide), .srcHalf(srcHalf), .srcByte(srcByte), .dataBus(dataBus),
		.dataDest(dataDest), .dataWrite(dataWrite), .destHigh16(destHigh16),
		.destLowByte(destLowByte), .microWord(microWord),
		.microValid(microValid));

	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic finish_test();
		$display("compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : finish_test

	always @(posedge hung) begin
		err_count++;
		finish_test();
	end

	function automatic logic [23:0] exp_bus(input logic [31:0] w);
		if (w[OP_HI:OP_LO] == OP_LOAD) return w[LIT_HI:0];
		if (w[OP_HI:OP_LO] != OP_EXEC) return 24'h0;
		case (w[SRC_HI:SRC_LO])
			SRC_WIDE: return srcWide;
			SRC_HALF: return {srcHalf, 8'h00};
			SRC_BYTE: return {srcByte, 16'h0000};
			default:  return 24'h0;
		endcase
	endfunction : exp_bus

	// Side outputs of one step: write strobe, destination, low read, high read
	function automatic logic [31:0] exp_side(input logic [31:0] w);
		logic [23:0] b;
		logic [3:0]  d;
		logic        moves;
		b = exp_bus(w);
		d = w[DST_HI:DST_LO];
		moves = w[OP_HI:OP_LO] == OP_LOAD || w[OP_HI:OP_LO] == OP_EXEC;
		if (!moves) d = DST_NONE;
		return {3'h0, moves && d != DST_NONE, d,
			(d == DST_WRITE_LOW) ? b[7:0] : b[23:16], b[23:8]};
	endfunction : exp_side

	// Trace of executed words, idle slots as zero, from the first executed step
	always @(posedge clock) begin
		if (rec && nTr < 17 && (nTr > 0 || microValid === 1'b1)) begin
			trW[nTr] <= (microValid === 1'b1) ? microWord : 32'h0;
			trB[nTr] <= dataBus;
			trX[nTr] <= {3'h0, dataWrite, dataDest, destLowByte, destHigh16};
			nTr      <= nTr + 1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	initial begin
		seed = 89;
		err_count = 0;
		n_compared = 0;
		nTr = 0;
		rec = 1'b0;
		rst_n = 1'b0;
		sampleClockPin = 1'b0;
		aluZero = 1'b0;
		aluSign = 1'b0;
		aluOverflow = 1'b0;
		aluFlagUpdate = 1'b0;
		lit = 24'($random(seed));
		srcWide = 24'($random(seed));
		srcHalf = 16'($random(seed)) | 16'h8000;
		srcByte = 8'($random(seed)) | 8'h01;
		cond = 8'($random(seed)) | 8'h10;
		extCondPin = 8'h00;
		// No nesting, every call leaves through its return address
		prog = '{{8'h61, lit}, 32'h10000003, 32'h00000aa2, 32'h20060009, 32'h20080006,
			32'h00000aa5, 32'h30002008, 32'h00000aa7, 32'h40001a0c, 32'h50041400,
			32'h01200000, 32'h70000000, 32'h03300000, 32'h02000000};
		expT = '{prog[0], prog[1], 0, prog[3], prog[4], 0, prog[6], 0, prog[8], 0,
			prog[12], prog[13], prog[9], prog[10], prog[10], prog[11], 0};
		repeat (6) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		check({30'h0, hresp, hreadyout}, 32'h1);
		check({8'h0, dataBus}, 32'h0);
		i_host.xfer(1'b0, 32'h1c, 32'h0, rd);
		check(rd, 32'h0);
		aluZero <= 1'b1;
		aluSign <= 1'b1;
		aluOverflow <= 1'b1;
		aluFlagUpdate <= 1'b1;
		@(posedge clock);
		aluZero <= 1'b0;
		aluSign <= 1'b0;
		aluOverflow <= 1'b0;
		aluFlagUpdate <= 1'b0;
		extCondPin <= cond;
		sampleClockPin <= 1'b1;
		repeat (4) @(posedge clock);
		sampleClockPin <= 1'b0;
		extCondPin <= ~cond;
		repeat (4) @(posedge clock);
		i_host.xfer(1'b0, 32'(REG_EXT_COND), 32'h0, rd);
		check(rd, {24'h0, cond});
		i_host.xfer(1'b0, 32'(REG_FLAGS), 32'h0, rd);
		check(rd, 32'h7);
		i_host.xfer(1'b1, 32'(REG_LOAD_ADDR), 32'h0, rd);
		for (p = 0; p < 14; p++) i_host.xfer(1'b1, 32'(REG_LOAD_DATA), prog[p], rd);
		i_host.xfer(1'b1, 32'(REG_CTRL), 32'h1, rd);
		rec <= 1'b1;
		n = 0;
		while (nTr < 17 && n < 200) begin
			@(posedge clock);
			n++;
		end
		check(nTr, 17);
		for (p = 0; p < 17; p++) check(trW[p], expT[p]);
		for (p = 0; p < 17; p++) begin
			check({8'h0, trB[p]}, {8'h0, exp_bus(expT[p])});
			check(trX[p], exp_side(expT[p]));
		end
		n = 0;
		repeat (20) begin
			@(posedge clock);
			if (microValid !== 1'b0) n++;
		end
		check(n, 0);
		// Twelve executed steps, parked waiting, nothing stacked or looping
		i_host.xfer(1'b0, 32'(REG_STATUS), 32'h0, rd);
		check(rd, {5'h00, 10'h00c, 5'h00, 3'h1, PC_ZERO});
		sampleClockPin <= 1'b1;
		n = 0;
		@(posedge clock);
		while (microValid !== 1'b1 && n < 20) begin
			@(posedge clock);
			n++;
		end
		check({31'h0, n < 20}, 32'h1);
		check(microWord, prog[0]);
		finish_test();
	end
endmodule : tb_dms_micro_sequencer
